// ### logic/sgc_pkg.sv
// shared constants and state types of the serial gain control port
package sgc_pkg;

  // frame layout: command byte then one data word, msb first
  localparam int CMD_W = 8;
  localparam int DATA_W = 16;
  localparam int FRAME_BITS = 24;
  localparam int CNT_W = 5;
  localparam int CMD_READ_BIT = 7;

  // bit counter marks inside a frame
  localparam logic [4:0] CMD_LAST = 5'h07;
  localparam logic [4:0] DATA_FIRST = 5'h08;
  localparam logic [4:0] FRAME_LAST = 5'h17;

  // serial clock made by the host from the core clock
  localparam int CORE_CLK_MHZ = 50;
  localparam int SCLK_PERIOD_NS = 320;
  localparam int SCLK_HALF_CYC = (SCLK_PERIOD_NS * CORE_CLK_MHZ) / 2000;

  // level seen on the shared data line when nobody drives it
  localparam logic SDIO_IDLE_LEVEL = 1'b1;

  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_SHIFT = 2'b01,
    DEV_DONE = 2'b10
  } sgc_dev_state_t;

  typedef enum logic [2:0] {
    HST_IDLE = 3'b000,
    HST_SETUP = 3'b001,
    HST_LOW = 3'b010,
    HST_HIGH = 3'b011,
    HST_END = 3'b100
  } sgc_host_state_t;

endpackage : sgc_pkg

// ### logic/sgc_if.sv
// three-wire link between serial host and gain control device
interface sgc_if;
  logic cs_n;
  logic sclk;
  logic host_sdo;
  logic host_sdo_en;
  logic dev_sdo;
  logic dev_sdo_en;
  logic sdio;

  // resolved shared data line, pulled up when released
  assign sdio = dev_sdo_en ? dev_sdo : (host_sdo_en ? host_sdo : sgc_pkg::SDIO_IDLE_LEVEL);

  modport dev (
    input cs_n,
    input sclk,
    input sdio,
    output dev_sdo,
    output dev_sdo_en
  );

  modport host (
    output cs_n,
    output sclk,
    output host_sdo,
    output host_sdo_en,
    input sdio
  );
endinterface : sgc_if

// ### logic/sgc_dev.sv
// device end of the serial gain control port
module sgc_dev (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  sgc_if.dev LINK,
  output logic WR_STB,
  output logic RD_REQ,
  output logic [7:0] CMD,
  output logic [15:0] WR_DATA,
  input wire logic [15:0] RD_DATA
);

  // synchronisers for the three link inputs
  logic cs_n_s1_q;
  logic cs_n_s2_q;
  logic sclk_s1_q;
  logic sclk_s2_q;
  logic sclk_prev_q;
  logic sdio_s1_q;
  logic sdio_s2_q;

  // frame state
  sgc_pkg::sgc_dev_state_t state_q;
  sgc_pkg::sgc_dev_state_t state_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [23:0] sh_q;
  logic [23:0] sh_d;
  logic [15:0] out_q;
  logic [15:0] out_d;
  logic rd_q;
  logic rd_d;
  logic sdo_q;
  logic sdo_d;
  logic oe_q;
  logic oe_d;

  // user side outputs
  logic wr_stb_q;
  logic wr_stb_d;
  logic rd_req_q;
  logic rd_req_d;
  logic [7:0] cmd_q;
  logic [7:0] cmd_d;
  logic [15:0] wdata_q;
  logic [15:0] wdata_d;

  // decoded link events
  logic selected;
  logic sclk_rise;
  logic sclk_fall;
  logic data_phase;
  logic [23:0] sh_next;

  // two flops per pin plus a third on the clock for edge detection; the first stage feeds only the second
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cs_n_s1_q <= 1'b1;
      cs_n_s2_q <= 1'b1;
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_prev_q <= 1'b0;
      sdio_s1_q <= 1'b1;
      sdio_s2_q <= 1'b1;
    end else begin
      cs_n_s1_q <= LINK.cs_n;
      cs_n_s2_q <= cs_n_s1_q;
      sclk_s1_q <= LINK.sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_prev_q <= sclk_s2_q;
      sdio_s1_q <= LINK.sdio;
      sdio_s2_q <= sdio_s1_q;
    end
  end

  // edges come from the synchronised clock, so data and clock stay aligned
  assign selected = ~cs_n_s2_q;
  assign sclk_rise = sclk_s2_q & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s2_q & sclk_prev_q;
  assign data_phase = rd_q && (cnt_q >= sgc_pkg::DATA_FIRST);
  assign sh_next = {sh_q[22:0], sdio_s2_q};

  // next-state logic of the serial engine
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    out_d = out_q;
    rd_d = rd_q;
    sdo_d = sdo_q;
    oe_d = oe_q;
    wr_stb_d = 1'b0;
    rd_req_d = 1'b0;
    cmd_d = cmd_q;
    wdata_d = wdata_q;
    case (state_q)
      sgc_pkg::DEV_IDLE: begin
        // clock edges while deselected never reach the counter
        if (selected) begin
          state_d = sgc_pkg::DEV_SHIFT;
          cnt_d = 5'h00;
          sh_d = 24'h000000;
          rd_d = 1'b0;
        end
      end
      sgc_pkg::DEV_SHIFT: begin
        if (!selected) begin
          // an aborted frame is dropped without a strobe
          state_d = sgc_pkg::DEV_IDLE;
          oe_d = 1'b0;
          rd_d = 1'b0;
          cnt_d = 5'h00;
        end else if (sclk_rise) begin
          cnt_d = cnt_q + 5'h01;
          // the pin is only read while the host owns it
          if (!data_phase) begin
            sh_d = sh_next;
          end
          if (cnt_q == sgc_pkg::CMD_LAST) begin
            cmd_d = sh_next[7:0];
            rd_d = sh_next[sgc_pkg::CMD_READ_BIT];
            rd_req_d = sh_next[sgc_pkg::CMD_READ_BIT];
          end
          if (cnt_q == sgc_pkg::FRAME_LAST) begin
            state_d = sgc_pkg::DEV_DONE;
            if (!rd_q) begin
              wr_stb_d = 1'b1;
              wdata_d = sh_next[15:0];
            end
          end
        end else if (sclk_fall && data_phase) begin
          // read word is taken late so the user has half a bit to answer
          oe_d = 1'b1;
          if (cnt_q == sgc_pkg::DATA_FIRST) begin
            sdo_d = RD_DATA[15];
            out_d = {RD_DATA[14:0], 1'b0};
          end else begin
            sdo_d = out_q[15];
            out_d = {out_q[14:0], 1'b0};
          end
        end
      end
      sgc_pkg::DEV_DONE: begin
        // driver kept on so the host can still sample the last bit
        if (!selected) begin
          state_d = sgc_pkg::DEV_IDLE;
          oe_d = 1'b0;
          rd_d = 1'b0;
          cnt_d = 5'h00;
        end
      end
      default: begin
        state_d = sgc_pkg::DEV_IDLE;
        oe_d = 1'b0;
        rd_d = 1'b0;
        cnt_d = 5'h00;
      end
    endcase
  end

  // registers of the serial engine
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= sgc_pkg::DEV_IDLE;
      cnt_q <= 5'h00;
      sh_q <= 24'h000000;
      out_q <= 16'h0000;
      rd_q <= 1'b0;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
      wr_stb_q <= 1'b0;
      rd_req_q <= 1'b0;
      cmd_q <= 8'h00;
      wdata_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      out_q <= out_d;
      rd_q <= rd_d;
      sdo_q <= sdo_d;
      oe_q <= oe_d;
      wr_stb_q <= wr_stb_d;
      rd_req_q <= rd_req_d;
      cmd_q <= cmd_d;
      wdata_q <= wdata_d;
    end
  end

  // link and user outputs straight from flops
  assign LINK.dev_sdo = sdo_q;
  assign LINK.dev_sdo_en = oe_q;
  assign WR_STB = wr_stb_q;
  assign RD_REQ = rd_req_q;
  assign CMD = cmd_q;
  assign WR_DATA = wdata_q;

endmodule : sgc_dev

// ### logic/sgc_host.sv
// host end of the serial gain control port: makes select, clock and frames
module sgc_host #(
  parameter int HALF_CYC = sgc_pkg::SCLK_HALF_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  sgc_if.host LINK,
  input wire logic START,
  input wire logic [7:0] CMD,
  input wire logic [15:0] WR_DATA,
  output logic BUSY,
  output logic DONE,
  output logic [15:0] RD_DATA
);

  logic sdio_s1_q;
  logic sdio_s2_q;
  logic [15:0] div_q;
  logic [15:0] div_d;
  logic tick;
  sgc_pkg::sgc_host_state_t state_q;
  sgc_pkg::sgc_host_state_t state_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [23:0] tx_q;
  logic [23:0] tx_d;
  logic [15:0] rx_q;
  logic [15:0] rx_d;
  logic rd_q;
  logic rd_d;
  logic cs_n_q;
  logic cs_n_d;
  logic sclk_q;
  logic sclk_d;
  logic sdo_q;
  logic sdo_d;
  logic oe_q;
  logic oe_d;
  logic busy_q;
  logic busy_d;
  logic done_q;
  logic done_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  // half-period enable; the divider rests while idle so the clock is stopped
  assign tick = (state_q != sgc_pkg::HST_IDLE) && (div_q == 16'(HALF_CYC - 1));

  // frame sequencer
  always_comb begin
    state_d = state_q;
    div_d = (state_q == sgc_pkg::HST_IDLE || tick) ? 16'h0000 : div_q + 16'h0001;
    cnt_d = cnt_q;
    tx_d = tx_q;
    rx_d = rx_q;
    rd_d = rd_q;
    cs_n_d = cs_n_q;
    sclk_d = sclk_q;
    sdo_d = sdo_q;
    oe_d = oe_q;
    busy_d = busy_q;
    done_d = 1'b0;
    rdata_d = rdata_q;
    case (state_q)
      sgc_pkg::HST_IDLE: begin
        if (START) begin
          rd_d = CMD[sgc_pkg::CMD_READ_BIT];
          tx_d = {CMD, CMD[sgc_pkg::CMD_READ_BIT] ? 16'h0000 : WR_DATA};
          cs_n_d = 1'b0;
          cnt_d = 5'h00;
          busy_d = 1'b1;
          state_d = sgc_pkg::HST_SETUP;
        end
      end
      sgc_pkg::HST_SETUP: begin
        if (tick) begin
          sdo_d = tx_q[23];
          tx_d = {tx_q[22:0], 1'b0};
          oe_d = 1'b1;
          state_d = sgc_pkg::HST_LOW;
        end
      end
      sgc_pkg::HST_LOW: begin
        if (tick) begin
          sclk_d = 1'b1;
          state_d = sgc_pkg::HST_HIGH;
        end
      end
      sgc_pkg::HST_HIGH: begin
        if (tick) begin
          // sampled at the end of the high phase to cover the device's latency
          sclk_d = 1'b0;
          rx_d = {rx_q[14:0], sdio_s2_q};
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == sgc_pkg::FRAME_LAST) begin
            state_d = sgc_pkg::HST_END;
            cs_n_d = 1'b1;
            oe_d = 1'b0;
          end else begin
            state_d = sgc_pkg::HST_LOW;
            sdo_d = tx_q[23];
            tx_d = {tx_q[22:0], 1'b0};
            oe_d = !(rd_q && (cnt_q >= sgc_pkg::CMD_LAST));
          end
        end
      end
      sgc_pkg::HST_END: begin
        if (tick) begin
          state_d = sgc_pkg::HST_IDLE;
          busy_d = 1'b0;
          done_d = 1'b1;
          rdata_d = rx_q;
        end
      end
      default: begin
        state_d = sgc_pkg::HST_IDLE;
        cs_n_d = 1'b1;
        sclk_d = 1'b0;
        oe_d = 1'b0;
        busy_d = 1'b0;
      end
    endcase
  end

  // registers, including the two-flop synchroniser on the data line
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sdio_s1_q <= 1'b1;
      sdio_s2_q <= 1'b1;
      div_q <= 16'h0000;
      state_q <= sgc_pkg::HST_IDLE;
      cnt_q <= 5'h00;
      tx_q <= 24'h000000;
      rx_q <= 16'h0000;
      rd_q <= 1'b0;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      sdio_s1_q <= LINK.sdio;
      sdio_s2_q <= sdio_s1_q;
      div_q <= div_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      rd_q <= rd_d;
      cs_n_q <= cs_n_d;
      sclk_q <= sclk_d;
      sdo_q <= sdo_d;
      oe_q <= oe_d;
      busy_q <= busy_d;
      done_q <= done_d;
      rdata_q <= rdata_d;
    end
  end

  assign LINK.cs_n = cs_n_q;
  assign LINK.sclk = sclk_q;
  assign LINK.host_sdo = sdo_q;
  assign LINK.host_sdo_en = oe_q;
  assign BUSY = busy_q;
  assign DONE = done_q;
  assign RD_DATA = rdata_q;

endmodule : sgc_host

// ### verif/sgc_checker.sv
// concurrent checks on the three-wire link between host and device
module sgc_checker (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic host_sdo,
  input wire logic host_sdo_en,
  input wire logic dev_sdo,
  input wire logic dev_sdo_en
);
  logic sclk_q;
  logic [4:0] rises_q;
  logic [4:0] rises_d;

  // count rising serial clock edges inside a selection
  always_comb begin
    rises_d = rises_q;
    if (cs_n) begin
      rises_d = 5'h00;
    end else if (sclk && !sclk_q) begin
      rises_d = rises_q + 5'h01;
    end
  end

  // the count clears only once select is seen high, so it still holds 24 at that edge
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sclk_q <= 1'b0;
      rises_q <= 5'h00;
    end else begin
      sclk_q <= sclk;
      rises_q <= rises_d;
    end
  end

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  a_idle_clock_low: assert property (cs_n |-> !sclk) else $error("serial clock runs while deselected");
  a_deselect_release: assert property (cs_n [*5] |-> !dev_sdo_en) else $error("device drives while deselected");
  a_no_clash: assert property (!(dev_sdo_en && host_sdo_en)) else $error("both ends drive the data line");
  a_clock_selected: assert property ($rose(sclk) |-> !cs_n) else $error("serial clock edge outside selection");
  a_drive_selected: assert property ($rose(dev_sdo_en) |-> !cs_n) else $error("device driver on without selection");
  a_host_change_low: assert property (host_sdo_en && $changed(host_sdo) |-> !sclk)
    else $error("host data changed in high phase");
  a_dev_change_low: assert property (dev_sdo_en && $changed(dev_sdo) |-> !sclk)
    else $error("device data changed in high phase");
  // six core cycles of high phase, matching the bench's host setting
  a_high_phase: assert property ($rose(sclk) |-> sclk [*6] ##1 !sclk) else $error("serial high phase length wrong");
  a_bit_ceiling: assert property ($rose(sclk) |-> rises_q < 5'h18) else $error("more than 24 clocks in a frame");
  a_full_frame: assert property ($rose(cs_n) |-> rises_q == 5'h18) else $error("frame ended short of 24 bits");
  a_read_turn: assert property ($fell(host_sdo_en) && !cs_n |-> rises_q == 5'h08)
    else $error("host released line at wrong bit");
endmodule : sgc_checker

// ### verif/tb.sv
// self-checking bench: host joined to device, plus a hand-driven second device
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  logic [7:0] h_cmd = 8'h00;
  logic [15:0] h_wdata = 16'h0000;
  logic [15:0] d_rdata = 16'h0000;
  logic busy;
  logic done;
  logic [15:0] h_rdata;
  logic wr_stb;
  logic rd_req;
  logic [7:0] d_cmd;
  logic [15:0] d_wdata;
  logic wr_stb_b;
  logic [7:0] d_cmd_b;
  logic [15:0] d_wdata_b;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  int stb_a = 0;
  int req_a = 0;
  int stb_b = 0;

  sgc_if link ();
  sgc_if link_b ();

  sgc_host #(.HALF_CYC(6)) sgc_host_i (.CORE_CLK(core_clk), .RESET_N(reset_n), .LINK(link), .START(start),
    .CMD(h_cmd), .WR_DATA(h_wdata), .BUSY(busy), .DONE(done), .RD_DATA(h_rdata));
  sgc_dev sgc_dev_i (.CORE_CLK(core_clk), .RESET_N(reset_n), .LINK(link), .WR_STB(wr_stb), .RD_REQ(rd_req),
    .CMD(d_cmd), .WR_DATA(d_wdata), .RD_DATA(d_rdata));
  // second device faces the bench, which breaks the host's rules on purpose
  sgc_dev sgc_dev_b_i (.CORE_CLK(core_clk), .RESET_N(reset_n), .LINK(link_b), .WR_STB(wr_stb_b), .RD_REQ(),
    .CMD(d_cmd_b), .WR_DATA(d_wdata_b), .RD_DATA(16'h0000));
  sgc_checker sgc_checker_i (.CORE_CLK(core_clk), .RESET_N(reset_n), .cs_n(link.cs_n), .sclk(link.sclk),
    .host_sdo(link.host_sdo), .host_sdo_en(link.host_sdo_en), .dev_sdo(link.dev_sdo), .dev_sdo_en(link.dev_sdo_en));

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  // strobes are one-cycle pulses, so count them rather than poll
  always @(posedge core_clk) begin
    cycles++;
    if (wr_stb === 1'b1) stb_a++;
    if (rd_req === 1'b1) req_a++;
    if (wr_stb_b === 1'b1) stb_b++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic host_frame(input logic [7:0] c, input logic [15:0] w);
    int n;
    @(negedge core_clk);
    start = 1'b1;
    h_cmd = c;
    h_wdata = w;
    @(negedge core_clk);
    start = 1'b0;
    check(24'(busy), 24'h1);
    for (n = 0; n < 600 && done !== 1'b1; n++) @(negedge core_clk);
    check(24'(done), 24'h1);
    // select phase, 24 low and high phases and a closing phase, six cycles each
    check(24'(n), 24'h12C);
    check(24'(busy), 24'h0);
  endtask : host_frame

  task automatic t_write();
    host_frame(8'h3C, 16'hA55A);
    check(24'(stb_a), 24'h1);
    check(24'(d_cmd), 24'h3C);
    check(24'(d_wdata), 24'hA55A);
  endtask : t_write

  task automatic t_read(input logic [15:0] w, input int nth);
    d_rdata = w;
    host_frame(8'hC3, 16'h1234);
    check(24'(req_a), 24'(nth));
    check(24'(d_cmd), 24'hC3);
    check(24'(stb_a), 24'h1);
    check(24'(h_rdata), 24'(w));
  endtask : t_read

  // one bench-made link clock period of 160 ns
  task automatic b_bit(input logic b);
    // data moves with the falling link clock, so both phases last four cycles
    link_b.host_sdo = b;
    repeat (4) @(negedge core_clk);
    link_b.sclk = 1'b1;
    repeat (4) @(negedge core_clk);
    link_b.sclk = 1'b0;
  endtask : b_bit

  task automatic b_frame(input logic [23:0] w, input int n);
    int i;
    @(negedge core_clk);
    link_b.cs_n = 1'b0;
    link_b.host_sdo_en = 1'b1;
    for (i = 0; i < n; i++) b_bit(i < 24 ? w[23 - i] : 1'b0);
    repeat (4) @(negedge core_clk);
    link_b.cs_n = 1'b1;
    link_b.host_sdo_en = 1'b0;
    repeat (8) @(negedge core_clk);
  endtask : b_frame

  task automatic t_faults();
    int i;
    link_b.host_sdo_en = 1'b1;
    for (i = 0; i < 24; i++) b_bit(1'b1);
    link_b.host_sdo_en = 1'b0;
    check(24'(stb_b), 24'h0);
    check(24'(link_b.dev_sdo_en), 24'h0);
    b_frame(24'h5A1357, 20);
    check(24'(stb_b), 24'h0);
    b_frame(24'h2BC0DE, 28);
    check(24'(stb_b), 24'h1);
    check(24'({d_cmd_b, d_wdata_b}), 24'h2BC0DE);
    b_frame(24'h118001, 24);
    check(24'(stb_b), 24'h2);
    check(24'(d_wdata_b), 24'h8001);
  endtask : t_faults

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    link_b.cs_n = 1'b1;
    link_b.sclk = 1'b0;
    link_b.host_sdo = 1'b0;
    link_b.host_sdo_en = 1'b0;
    repeat (8) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
    t_write();
    t_read(16'h9E71, 1);
    t_read(16'h618E, 2);
    t_faults();
    wrap_up();
  end
endmodule : tb
